// ===== hdl/low_power_reset_control.sv
// power-mode sequencing, reset sequencing and reset-cause status
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// What the document requires
// R1: software sets duty before enabling duty halt
// R2: halt cpu when its time slot expires
// R3: duty step one thirty-first, changeable live
// R4: duty halt ends: clear, interrupt, reset, sleep
// R5: select 0 plus sleep instruction gives idle
// R6: gate core clock only once core idle
// R7: idle left on interrupt or reset
// R8: select 1 sleep stops cpu, pll, clock pin
// R9: sleep blocks arbiter, sdram to self-refresh
// R10: stop clocks after bus idle, self-refresh
// R11: software quiesces peripherals before sleep
// R12: sleep left on interrupt, watchdog, power-on
// R13: bit 1 flags watchdog reset, sticky
// R14: bit 0 flags power-on reset, sticky; a watchdog reset clears it in this block
// R15: flags clear on zero, ignore one
// R16: status bits 31:2 read zero
// R17: reset pin low resets at once, pll off
// R18: pin held low until power stable
// R19: watchdog reset within two slow clocks
// R20: watchdog reset held ten milliseconds, pll off
// R21: select 00 idle, 01 sleep, others reserved
// R22: wake restores clocks, sdram before grants
module low_power_reset_control #(
	parameter int WDT_HOLD = lp_reset_pkg::WDT_HOLD_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic sleep_instr,
	input wire logic slot_expired,
	input wire logic core_idle,
	input wire logic irq,
	input wire logic bus_idle,
	input wire logic self_refresh_ack,
	input wire logic watchdog_overflow,
	input wire logic slow_32k_clock,
	output lp_reset_pkg::power_ctl_s ctl,
	output logic internal_reset,
	output logic watchdog_clear
);
	logic [1:0] low_power_select, next_low_power_select;
	logic light_halt, next_light_halt;
	logic [lp_reset_pkg::DUTY_W-1:0] duty, next_duty;
	logic power_on_flag, next_power_on_flag;
	logic watchdog_flag, next_watchdog_flag;
	logic [31:0] next_rdata;
	lp_reset_pkg::mode_e mode, next_mode;
	logic [lp_reset_pkg::DUTY_W-1:0] slot_cnt, next_slot_cnt;
	logic [31:0] hold_cnt, next_hold_cnt;
	logic wdt_reset, next_wdt_reset;
	logic [1:0] slow_edge_cnt, next_slow_edge_cnt;
	logic arm, next_arm;
	logic wdt_s1, wdt_s2, slow_s1, slow_s2, slow_s3;
	logic slow_rise;
	logic duty_halt;
	logic is_ctl_wr, is_stat_wr;

	// input synchronisers
	always_ff @(posedge core_clk) begin
		wdt_s1 <= watchdog_overflow;
		wdt_s2 <= wdt_s1;
		slow_s1 <= slow_32k_clock;
		slow_s2 <= slow_s1;
		slow_s3 <= slow_s2;
	end
	assign slow_rise = slow_s2 & ~slow_s3;

	assign is_ctl_wr = wr && addr == lp_reset_pkg::LOW_POWER_CONTROL_ADDR;
	assign is_stat_wr = wr && addr == lp_reset_pkg::RESET_CAUSE_STATUS_ADDR;

	// registers and read path
	always_comb begin
		next_low_power_select = low_power_select;
		next_light_halt = light_halt;
		next_duty = duty;
		next_power_on_flag = power_on_flag;
		next_watchdog_flag = watchdog_flag;
		next_rdata = 32'h0;
		if (is_ctl_wr) begin
			next_low_power_select = wdata[lp_reset_pkg::SELECT_LSB +: 2];
			next_light_halt = wdata[lp_reset_pkg::HALT_EN_BIT];
			next_duty = wdata[lp_reset_pkg::DUTY_LSB +: lp_reset_pkg::DUTY_W]; // see R3
		end
		if (light_halt && (irq || (sleep_instr && mode == lp_reset_pkg::ST_RUN))) begin
			next_light_halt = 1'b0; // see R4
		end
		if (is_stat_wr && !wdata[lp_reset_pkg::POWER_ON_FLAG_BIT]) begin
			next_power_on_flag = 1'b0; // see R15
		end
		if (is_stat_wr && !wdata[lp_reset_pkg::WATCHDOG_FLAG_BIT]) begin
			next_watchdog_flag = 1'b0; // see R15
		end
		if (wdt_reset) begin
			next_watchdog_flag = 1'b1; // see R13
			next_power_on_flag = 1'b0;
			next_low_power_select = lp_reset_pkg::SELECT_IDLE;
			next_light_halt = 1'b0; // see R4
			next_duty = lp_reset_pkg::DUTY_RESET;
		end
		if (rd) begin
			unique case (addr)
				lp_reset_pkg::RESET_CAUSE_STATUS_ADDR:
					next_rdata = {30'h0, watchdog_flag, power_on_flag}; // see R16
				lp_reset_pkg::LOW_POWER_CONTROL_ADDR:
					next_rdata = {24'h0, duty, light_halt, low_power_select};
				default:
					next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			low_power_select <= lp_reset_pkg::SELECT_IDLE;
			light_halt <= 1'b0;
			duty <= lp_reset_pkg::DUTY_RESET;
			power_on_flag <= 1'b1; // see R14
			watchdog_flag <= 1'b0;
			rdata <= 32'h0;
		end else begin
			low_power_select <= next_low_power_select;
			light_halt <= next_light_halt;
			duty <= next_duty;
			power_on_flag <= next_power_on_flag;
			watchdog_flag <= next_watchdog_flag;
			rdata <= next_rdata;
		end
	end

	// duty-cycle slot counter, 31 slots per frame
	always_comb begin
		next_slot_cnt = slot_cnt + 5'h01;
		if (slot_cnt >= lp_reset_pkg::DUTY_FULL - 5'h01) begin
			next_slot_cnt = 5'h00;
		end
		if (!light_halt) begin
			next_slot_cnt = 5'h00;
		end
	end
	// halted while slot exhausted, duty of 31 never halts
	assign duty_halt = light_halt && slot_expired && slot_cnt >= duty; // see R2 R3

	// watchdog reset: first slow edge after arming, then ten ms hold
	always_comb begin
		next_arm = arm;
		next_slow_edge_cnt = slow_edge_cnt;
		next_wdt_reset = wdt_reset;
		next_hold_cnt = hold_cnt;
		if (wdt_s2 && !arm && !wdt_reset) begin
			next_arm = 1'b1;
			next_slow_edge_cnt = 2'h0;
		end
		if (arm && slow_rise) begin
			next_slow_edge_cnt = slow_edge_cnt + 2'h1;
		end
		if (arm && (slow_rise || slow_edge_cnt != 2'h0)) begin
			next_arm = 1'b0; // see R19
			next_wdt_reset = 1'b1;
			next_hold_cnt = 32'h0;
		end
		if (wdt_reset) begin
			next_hold_cnt = hold_cnt + 32'h1;
			if (hold_cnt >= 32'(WDT_HOLD - 1)) begin
				next_wdt_reset = 1'b0; // see R20
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			arm <= 1'b0;
			slow_edge_cnt <= 2'h0;
			wdt_reset <= 1'b0;
			hold_cnt <= 32'h0;
			slot_cnt <= 5'h00;
		end else begin
			arm <= next_arm;
			slow_edge_cnt <= next_slow_edge_cnt;
			wdt_reset <= next_wdt_reset;
			hold_cnt <= next_hold_cnt;
			slot_cnt <= next_slot_cnt;
		end
	end

	// internal reset from pin (immediate) or watchdog; clears watchdog source
	assign internal_reset = !resetn || wdt_reset; // see R17 R20
	assign watchdog_clear = wdt_reset; // see R20

	// power mode machine
	always_comb begin
		next_mode = mode;
		unique case (mode)
			lp_reset_pkg::ST_RUN: begin
				if (sleep_instr && low_power_select == lp_reset_pkg::SELECT_IDLE) begin
					next_mode = lp_reset_pkg::ST_IDLE_WAIT; // see R5 R21
				end else if (sleep_instr && low_power_select == lp_reset_pkg::SELECT_SLEEP) begin
					next_mode = lp_reset_pkg::ST_SLEEP_DRAIN; // see R8 R21
				end
			end
			lp_reset_pkg::ST_IDLE_WAIT: begin
				if (irq) begin
					next_mode = lp_reset_pkg::ST_RUN;
				end else if (core_idle) begin
					next_mode = lp_reset_pkg::ST_IDLE; // see R6
				end
			end
			lp_reset_pkg::ST_IDLE: begin
				if (irq) begin
					next_mode = lp_reset_pkg::ST_RUN; // see R7
				end
			end
			lp_reset_pkg::ST_SLEEP_DRAIN: begin
				if (bus_idle && self_refresh_ack) begin
					next_mode = lp_reset_pkg::ST_SLEEP; // see R10
				end
			end
			lp_reset_pkg::ST_SLEEP: begin
				if (irq) begin
					next_mode = lp_reset_pkg::ST_WAKE; // see R12
				end
			end
			lp_reset_pkg::ST_WAKE: begin
				if (!self_refresh_ack) begin
					next_mode = lp_reset_pkg::ST_RUN; // see R22
				end
			end
			default: next_mode = lp_reset_pkg::ST_RUN;
		endcase
		if (wdt_reset) begin
			next_mode = lp_reset_pkg::ST_RUN; // see R7 R12
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			mode <= lp_reset_pkg::ST_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	// outputs per mode; pll and clock pin off during any reset
	always_comb begin
		ctl.cpu_halt = duty_halt || (mode != lp_reset_pkg::ST_RUN); // see R2 R5
		ctl.cpu_clk_en = !(mode == lp_reset_pkg::ST_IDLE || mode == lp_reset_pkg::ST_SLEEP);
		ctl.periph_clk_en = mode != lp_reset_pkg::ST_SLEEP; // see R8 R10
		ctl.pll_on = !internal_reset && mode != lp_reset_pkg::ST_SLEEP; // see R8 R17 R20
		ctl.clk_out_en = !internal_reset && mode != lp_reset_pkg::ST_SLEEP; // see R8
		ctl.bus_block = mode == lp_reset_pkg::ST_SLEEP_DRAIN || mode == lp_reset_pkg::ST_SLEEP
			|| mode == lp_reset_pkg::ST_WAKE; // see R9 R22
		ctl.self_refresh_req = mode == lp_reset_pkg::ST_SLEEP_DRAIN
			|| mode == lp_reset_pkg::ST_SLEEP; // see R9
	end

	property p_idle_gate;
		@(posedge core_clk) disable iff (!resetn)
		(mode == lp_reset_pkg::ST_IDLE_WAIT && !core_idle) |=> ctl.cpu_clk_en;
	endproperty
	a_idle_gate: assert property (p_idle_gate) else $error("core clock gated early"); // see R6

	property p_sleep_clk;
		@(posedge core_clk) disable iff (!resetn)
		(mode == lp_reset_pkg::ST_SLEEP) |-> $past(bus_idle) && !ctl.pll_on;
	endproperty
	a_sleep_clk: assert property (p_sleep_clk) else $error("sleep before bus idle"); // see R10

	property p_block;
		@(posedge core_clk) disable iff (!resetn || wdt_reset)
		(mode == lp_reset_pkg::ST_RUN && sleep_instr
			&& low_power_select == lp_reset_pkg::SELECT_SLEEP)
			|=> ctl.bus_block && ctl.self_refresh_req;
	endproperty
	a_block: assert property (p_block) else $error("sleep entry not blocking bus"); // see R9

	property p_wake;
		@(posedge core_clk) disable iff (!resetn || wdt_reset)
		(mode == lp_reset_pkg::ST_SLEEP && irq) |=> ctl.bus_block && ctl.periph_clk_en;
	endproperty
	a_wake: assert property (p_wake) else $error("wake order wrong"); // see R12 R22

	property p_wflag;
		@(posedge core_clk) disable iff (!resetn)
		$rose(wdt_reset) |=> watchdog_flag && !power_on_flag;
	endproperty
	a_wflag: assert property (p_wflag) else $error("watchdog flag not set"); // see R13

	property p_clear1;
		@(posedge core_clk) disable iff (!resetn || wdt_reset)
		(is_stat_wr && wdata[lp_reset_pkg::POWER_ON_FLAG_BIT]) |=> power_on_flag == $past(power_on_flag);
	endproperty
	a_clear1: assert property (p_clear1) else $error("write one changed flag"); // see R15 R14

	property p_rsv;
		@(posedge core_clk) disable iff (!resetn)
		$past(rd && addr == lp_reset_pkg::RESET_CAUSE_STATUS_ADDR) |-> rdata[31:2] == 30'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits nonzero"); // see R16

	property p_wdt_fast;
		@(posedge core_clk) disable iff (!resetn)
		(arm && slow_rise) |=> wdt_reset && !arm;
	endproperty
	a_wdt_fast: assert property (p_wdt_fast) else $error("watchdog reset late"); // see R19
endmodule // low_power_reset_control

// ===== hdl/lp_reset_pkg.sv
// constants and types for the low-power and reset sequencer
package lp_reset_pkg;
	localparam logic [31:0] RESET_CAUSE_STATUS_ADDR = 32'h10000008;
	localparam logic [31:0] LOW_POWER_CONTROL_ADDR = 32'h10000004;
	localparam int POWER_ON_FLAG_BIT = 0;
	localparam int WATCHDOG_FLAG_BIT = 1;
	localparam int SELECT_LSB = 0;
	localparam int HALT_EN_BIT = 2;
	localparam int DUTY_LSB = 3;
	localparam int DUTY_W = 5;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 5'h1F;
	localparam logic [DUTY_W-1:0] DUTY_RESET = 5'h1F;
	localparam logic [1:0] SELECT_IDLE = 2'h0;
	localparam logic [1:0] SELECT_SLEEP = 2'h1;
	localparam int CLK_HZ = 100_000_000;
	localparam int WDT_HOLD_MS = 10;
	localparam int WDT_HOLD_CYCLES = CLK_HZ / 1000 * WDT_HOLD_MS;
	localparam int SLOW_EDGES = 2;

	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_IDLE_WAIT = 3'h1,
		ST_IDLE = 3'h2,
		ST_SLEEP_DRAIN = 3'h3,
		ST_SLEEP = 3'h4,
		ST_WAKE = 3'h5
	} mode_e;

	typedef struct packed {
		logic cpu_clk_en;
		logic cpu_halt;
		logic periph_clk_en;
		logic pll_on;
		logic clk_out_en;
		logic bus_block;
		logic self_refresh_req;
	} power_ctl_s;
endpackage

// ===== tb/far_side_model.sv
// core, bus arbiter and memory controller seen from the sequencer
`timescale 1ns/1ps
module far_side_model #(
	parameter int LAG = 3
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire lp_reset_pkg::power_ctl_s ctl,
	input wire logic sleep_instr,
	output logic core_idle,
	output logic bus_idle,
	output logic self_refresh_ack
);
	int ccnt;
	int bcnt;
	int scnt;
	logic blk_q;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ccnt <= 0;
			bcnt <= 0;
			scnt <= 0;
			blk_q <= 1'b0;
			self_refresh_ack <= 1'b0;
		end else begin
			blk_q <= ctl.bus_block;
			ccnt <= sleep_instr ? LAG : (ccnt > 0 ? ccnt - 1 : 0);
			bcnt <= (ctl.bus_block && !blk_q) ? LAG : (bcnt > 0 ? bcnt - 1 : 0);
			scnt <= (ctl.self_refresh_req != self_refresh_ack) ? scnt + 1 : 0;
			if (scnt == LAG) begin
				self_refresh_ack <= ctl.self_refresh_req;
			end
		end
	end
	assign core_idle = (ccnt == 0);
	assign bus_idle = blk_q && (bcnt == 0);
endmodule // far_side_model

// ===== tb/tb_top.sv
// self-checking bench for the low-power and reset sequencer
`timescale 1ns/1ps
module tb_top;
	localparam int HOLD = 20;
	localparam logic [31:0] ST = lp_reset_pkg::RESET_CAUSE_STATUS_ADDR;
	localparam logic [31:0] LC = lp_reset_pkg::LOW_POWER_CONTROL_ADDR;
	logic core_clk = 0, resetn = 0, wr = 0, rd = 0, sleep_instr = 0, slot_expired = 0;
	logic irq = 0, watchdog_overflow = 0, slow_32k_clock = 0;
	logic [31:0] addr = '0, wdata = '0, rdata, stat_m, lpc_m;
	logic [2:0] slow_div = '0;
	logic core_idle, bus_idle, self_refresh_ack, internal_reset, watchdog_clear;
	lp_reset_pkg::power_ctl_s ctl;
	int err_total = 0, cmp_count = 0, n, k;
	low_power_reset_control #(.WDT_HOLD(HOLD)) i_low_power_reset_control (.core_clk(core_clk),
		.resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sleep_instr(sleep_instr), .slot_expired(slot_expired), .core_idle(core_idle), .irq(irq),
		.bus_idle(bus_idle), .self_refresh_ack(self_refresh_ack),
		.watchdog_overflow(watchdog_overflow), .slow_32k_clock(slow_32k_clock), .ctl(ctl),
		.internal_reset(internal_reset), .watchdog_clear(watchdog_clear));
	far_side_model i_far_side_model (.core_clk(core_clk), .resetn(resetn), .ctl(ctl),
		.sleep_instr(sleep_instr), .core_idle(core_idle), .bus_idle(bus_idle),
		.self_refresh_ack(self_refresh_ack));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		slow_div <= slow_div + 3'h1;
		slow_32k_clock <= slow_div[2];
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		if (a == ST) stat_m = stat_m & d & 32'h3;
		if (a == LC) lpc_m = d & 32'hFF;
	endtask
	task automatic rd_reg(input logic [31:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 check(rdata, exp, "read");
	endtask
	task automatic sleep_cmd;
		@(posedge core_clk);
		sleep_instr <= 1'b1;
		@(posedge core_clk);
		sleep_instr <= 1'b0;
		#1;
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#50us;
		err_total++;
		$display("BAD %0t timeout", $time);
		finish_test;
	end
	initial begin
		void'($urandom(79));
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		stat_m = 32'h1;
		lpc_m = 32'hF8;
		rd_reg(ST, stat_m);
		rd_reg(LC, lpc_m);
		wr_reg(ST, 32'hFFFFFFFF);
		rd_reg(ST, stat_m);
		wr_reg(ST, 32'h0);
		rd_reg(ST, stat_m);
		rd_reg(32'h1000000C, 32'h0);
		$display("register test done");
		wr_reg(LC, 32'h0);
		slot_expired <= 1'b1;
		wr_reg(LC, 32'h4);
		for (n = 0; n < 40 && ctl.cpu_halt !== 1'b1; n++) @(posedge core_clk);
		#1 check(ctl.cpu_halt, 1'b1, "halt");
		wr_reg(LC, 32'h4 | (($urandom % 32) << 3));
		k = 0;
		repeat (31) begin
			@(posedge core_clk);
			#1 k += ctl.cpu_halt;
		end
		check(k, 31 - lpc_m[7:3], "duty share");
		rd_reg(LC, lpc_m);
		@(posedge core_clk);
		irq <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 check(ctl.cpu_halt, 1'b0, "halt irq");
		@(posedge core_clk);
		irq <= 1'b0;
		lpc_m = lpc_m & 32'hFB;
		rd_reg(LC, lpc_m);
		wr_reg(LC, 32'h4);
		repeat (2) @(posedge core_clk);
		#1 check(ctl.cpu_halt, 1'b1, "halt again");
		wr_reg(LC, 32'h0);
		repeat (2) @(posedge core_clk);
		#1 check(ctl.cpu_halt, 1'b0, "halt clear");
		@(posedge core_clk);
		slot_expired <= 1'b0;
		$display("duty test done");
		sleep_cmd;
		check(ctl.cpu_clk_en, 1'b1, "core busy");
		for (n = 0; n < 30 && ctl.cpu_clk_en !== 1'b0; n++) @(posedge core_clk);
		#1 check({ctl.cpu_clk_en, ctl.cpu_halt}, 2'h1, "idle");
		@(posedge core_clk);
		irq <= 1'b1;
		for (n = 0; n < 30 && ctl.cpu_clk_en !== 1'b1; n++) @(posedge core_clk);
		#1 check(ctl.cpu_clk_en, 1'b1, "idle wake");
		@(posedge core_clk);
		irq <= 1'b0;
		$display("idle test done");
		wr_reg(LC, lpc_m | 32'h1);
		sleep_cmd;
		for (n = 0; n < 5 && ctl.bus_block !== 1'b1; n++) @(posedge core_clk);
		#1 check({ctl.bus_block, ctl.self_refresh_req, ctl.periph_clk_en}, 3'h7, "drain");
		for (n = 0; n < 30 && ctl.pll_on !== 1'b0; n++) @(posedge core_clk);
		#1 check({ctl.pll_on, ctl.clk_out_en}, 2'h0, "pll off");
		check({ctl.periph_clk_en, self_refresh_ack}, 2'h1, "sleep");
		@(posedge core_clk);
		irq <= 1'b1;
		for (n = 0; n < 40 && ctl.bus_block !== 1'b0; n++) @(posedge core_clk);
		#1 check({self_refresh_ack, ctl.cpu_clk_en}, 2'h1, "wake");
		check({ctl.pll_on, ctl.periph_clk_en}, 2'h3, "wake clocks");
		@(posedge core_clk);
		irq <= 1'b0;
		$display("sleep test done");
		watchdog_overflow <= 1'b1;
		for (n = 0; n < 40 && internal_reset !== 1'b1; n++) @(posedge core_clk);
		#1 check(watchdog_clear, 1'b1, "wdt clear");
		check(ctl.pll_on, 1'b0, "wdt pll");
		check(n <= 22, 1'b1, "wdt latency");
		for (n = 0; n < 60 && internal_reset === 1'b1; n++) begin
			@(posedge core_clk);
			if (watchdog_clear === 1'b1) watchdog_overflow <= 1'b0;
		end
		check(n >= HOLD - 1 && n <= HOLD + 2, 1'b1, "wdt hold");
		stat_m = 32'h2;
		lpc_m = 32'hF8;
		rd_reg(ST, stat_m);
		rd_reg(LC, lpc_m);
		@(posedge core_clk);
		resetn <= 1'b0;
		#1 check({internal_reset, ctl.pll_on}, 2'h2, "pin reset");
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		stat_m = 32'h1;
		rd_reg(ST, stat_m);
		$display("reset test done");
		finish_test;
	end
endmodule // tb_top
